// ### verif/lesc_lamp_model.sv
// Lamp model for the three indicator pins of lesc_top.
// Assumes plain active-high lamp drives with no filtering.
`timescale 1ns/100ps
`default_nettype none
module lesc_lamp_model (
  input  wire logic [2:0] indicator,
  output logic      [2:0] lamp
);
  assign lamp = indicator;
endmodule
`default_nettype wire

// ### verif/lesc_top_props.sv
// Port checker for lesc_top, bound below.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module lesc_top_props (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   reg_wr,
  input wire logic [4:0]             reg_addr,
  input wire logic [15:0]            reg_wdata,
  input wire logic [15:0]            reg_rdata,
  input wire lesc_pkg::lesc_status_s status,
  input wire logic [2:0]             indicator
);
  // Shadow copy, so selects can be judged from the ports alone.
  logic [15:0] cfg;
  wire logic [3:0] sel = cfg[15:12];
  wire logic en = cfg[lesc_pkg::STRETCH_EN_BIT];
  wire logic hit = reg_addr == lesc_pkg::CFG_ADDR;
  always_ff @(posedge clk) begin
    if (rst) cfg <= lesc_pkg::CFG_RESET;
    else if (reg_wr && hit) cfg <= reg_wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RST_CFG: assert property ($past(rst) && hit
    |=> reg_rdata == 16'h0422) else $error("reset value wrong");
  AST_WR_RD: assert property (reg_wr && hit ##1 hit
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback wrong");
  AST_FORCE_ON: assert property (sel == lesc_pkg::SEL_ON
    |=> indicator[0]) else $error("forced on not lit");
  AST_FORCE_OFF: assert property (sel == lesc_pkg::SEL_OFF
    |=> !indicator[0]) else $error("forced off lit");
  AST_RAW: assert property (!en && sel == lesc_pkg::SEL_TX
    |=> indicator[0] == $past(status.tx)) else $error("raw tx wrong");
  AST_LINK: assert property (sel == lesc_pkg::SEL_LINK
    |=> indicator[0] == $past(status.link)) else $error("link wrong");
  AST_DUPLEX: assert property (sel == lesc_pkg::SEL_DUPLEX
    |=> indicator[0] == $past(status.duplex)) else $error("duplex wrong");
  AST_SPEED: assert property (sel == lesc_pkg::SEL_SPEED
    |=> indicator[0] == $past(status.speed_100)) else $error("speed wrong");
  AST_HOLD: assert property (en && sel == lesc_pkg::SEL_RX && status.rx
    |=> indicator[0] [*8]) else $error("stretch dropped early");
endmodule
bind lesc_top lesc_top_props u_props (.clk(clk), .rst(rst), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .status(status), .indicator(indicator));
`default_nettype wire

// ### verif/lesc_top_tb.sv
// Self-checking bench for lesc_top with the lamp model on its pins.
// Assumes only this bench drives the register port and status.
`timescale 1ns/100ps
`default_nettype none
module lesc_top_tb;
  // A short millisecond keeps the longest stretch near a thousand cycles.
  localparam int MS = 10;
  logic clk = 0, rst = 1, reg_wr = 0, look = 0, look_d = 0;
  logic [4:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata;
  lesc_pkg::lesc_status_s st = '0;
  logic [2:0] indicator, lamp;
  logic [17:0] q[$];
  logic [17:0] e;
  logic watch = 0;
  logic [1:0] dark = '0;
  logic [31:0] r = 32'h86a3;
  logic [1:0] per;
  int n_errors = 0, n_checks = 0, t;
  lesc_top #(.MS_CYCLES(MS)) uut (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .status(st), .indicator(indicator));
  lesc_lamp_model u_lamp (.indicator(indicator), .lamp(lamp));
  always #10 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string n, input logic [15:0] s, x);
    n_checks++;
    if (s !== x) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic test_done;
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] d);
    reg_wr <= 1;
    reg_addr <= lesc_pkg::CFG_ADDR;
    reg_wdata <= d;
    tick(1);
    reg_wr <= 0;
    tick(2);
  endtask
  task automatic note(input logic [1:0] k, input logic [15:0] x,
                      input logic [4:0] a);
    reg_addr <= a;
    q.push_back({k, x});
    look <= 1;
    tick(1);
    look <= 0;
    tick(1);
  endtask
  task automatic pulse;
    st.rx <= 1;
    st.col <= 1;
    tick(1);
    st.rx <= 0;
    st.col <= 0;
  endtask
  always @(posedge clk) look_d <= look;
  // Sticky record of each combined lamp going dark while watched.
  always @(posedge clk) dark <= watch ? (dark | ~lamp[1:0]) : 2'b00;
  always @(negedge clk) if (look_d) begin
    e = q.pop_front();
    if (e[17]) check("blink", {14'h0, dark}, e[15:0]);
    else if (e[16]) check("lamp", {13'h0, lamp}, e[15:0]);
    else check("reg_rdata", reg_rdata, e[15:0]);
  end
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
  initial begin
    tick(5);
    rst <= 0;
    note(0, 16'h0422, lesc_pkg::CFG_ADDR);
    note(0, 16'h0000, 5'h03);
    repeat (4) begin
      r = lfsr(r);
      wr(r[15:0]);
      note(0, r[15:0], lesc_pkg::CFG_ADDR);
    end
    for (int c = 0; c < 16; c++) begin
      r = lfsr(r);
      wr({c[3:0], c[3:0], c[3:0], r[3:0]});
      repeat (12) begin
        r = lfsr(r);
        st <= r[5:0];
        tick(1);
      end
      st <= '0;
      tick(10);
    end
    wr({lesc_pkg::SEL_LINK_RX, lesc_pkg::SEL_DUP_COL, lesc_pkg::SEL_ON, 4'h0});
    st <= 6'b000011;
    tick(2);
    note(1, 16'h0007, lesc_pkg::CFG_ADDR);
    st <= '0;
    for (int p = 0; p < 4; p++) begin
      per = (p == 3) ? 2'b00 : p[1:0];
      t = (per == 2'b00) ? 30 : (per == 2'b01) ? 60 : 100;
      wr({lesc_pkg::SEL_RX, lesc_pkg::SEL_OFF, lesc_pkg::SEL_OFF, per,
          p != 3, 1'b0});
      pulse();
      tick(20 * MS);
      pulse();
      tick((t - 2) * MS);
      note(1, {15'h0, p != 3}, lesc_pkg::CFG_ADDR);
      tick(3 * MS);
      note(1, 16'h0000, lesc_pkg::CFG_ADDR);
    end
    wr({lesc_pkg::SEL_LINK_RX, lesc_pkg::SEL_DUP_COL, lesc_pkg::SEL_OFF,
        4'h0});
    st <= 6'h03;
    tick(2);
    watch <= 1;
    repeat (12) begin
      pulse();
      tick(20 * MS);
    end
    note(2, 16'h0003, lesc_pkg::CFG_ADDR);
    watch <= 0;
    tick(20 * MS);
    note(1, 16'h0003, lesc_pkg::CFG_ADDR);
    tick(4);
    test_done();
  end
endmodule
`default_nettype wire

// ### verilog/lesc_pkg.sv
// Constants and carriers for the indicator stretch and select block.
// Assumes a 50 MHz clock; times are in milliseconds.
package lesc_pkg;
  // ==========================================================================
  // Register map and fields
  localparam logic [4:0]  CFG_ADDR        = 5'h14;
  localparam logic [15:0] CFG_RESET       = 16'h0422;
  localparam int          SEL1_LSB        = 12;
  localparam int          SEL2_LSB        = 8;
  localparam int          SEL3_LSB        = 4;
  localparam int          PERIOD_LSB      = 2;
  localparam int          STRETCH_EN_BIT  = 1;
  // ==========================================================================
  // Select codes
  localparam logic [3:0] SEL_SPEED     = 4'h0;
  localparam logic [3:0] SEL_TX        = 4'h1;
  localparam logic [3:0] SEL_RX        = 4'h2;
  localparam logic [3:0] SEL_COL       = 4'h3;
  localparam logic [3:0] SEL_LINK      = 4'h4;
  localparam logic [3:0] SEL_DUPLEX    = 4'h5;
  localparam logic [3:0] SEL_ACT       = 4'h7;
  localparam logic [3:0] SEL_ON        = 4'h8;
  localparam logic [3:0] SEL_OFF       = 4'h9;
  localparam logic [3:0] SEL_FAST      = 4'ha;
  localparam logic [3:0] SEL_SLOW      = 4'hb;
  localparam logic [3:0] SEL_LINK_RX   = 4'hc;
  localparam logic [3:0] SEL_LINK_ACT  = 4'hd;
  localparam logic [3:0] SEL_DUP_COL   = 4'he;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int CYC_PER_MS   = CLK_HZ / 1000;
  localparam int TIME0_MS     = 30;
  localparam int TIME1_MS     = 60;
  localparam int TIME2_MS     = 100;
  localparam int FAST_MS      = 100;
  localparam int SLOW_MS      = 500;
  localparam int MS_W         = 10;
  // ==========================================================================
  // Status inputs from the port
  typedef struct packed {
    logic speed_100;
    logic tx;
    logic rx;
    logic col;
    logic link;
    logic duplex;
  } lesc_status_s;
endpackage

// ### verilog/lesc_top.sv
// Indicator configuration register, event stretching and indicator select.
// Assumes a management serial front end giving word writes and reads.
// Status inputs are taken as synchronous to clk, high for each event cycle.
`timescale 1ns/100ps
`default_nettype none
module lesc_top #(
  parameter int MS_CYCLES = lesc_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register port
  input  wire logic                  reg_wr,
  input  wire logic [4:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  output logic      [15:0]           reg_rdata,
  // Port status
  input  wire lesc_pkg::lesc_status_s status,
  // Indicators, high means lit
  output logic      [2:0]            indicator
);
  // ==========================================================================
  // Configuration register
  logic [15:0] cfg;
  wire         cfg_hit = reg_wr && (reg_addr == lesc_pkg::CFG_ADDR);
  wire  [3:0]  sel [3];
  assign sel[0] = cfg[lesc_pkg::SEL1_LSB +: 4];
  assign sel[1] = cfg[lesc_pkg::SEL2_LSB +: 4];
  assign sel[2] = cfg[lesc_pkg::SEL3_LSB +: 4];
  wire  [1:0]  period_sel = cfg[lesc_pkg::PERIOD_LSB +: 2];
  wire         stretch_en = cfg[lesc_pkg::STRETCH_EN_BIT];

  // Bit 0 is kept as plain storage so software reads back what it wrote.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= lesc_pkg::CFG_RESET;
    end else if (cfg_hit) begin
      cfg <= reg_wdata;
    end
  end

  // Read data is registered, so it answers the address of the last cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= (reg_addr == lesc_pkg::CFG_ADDR) ? cfg : 16'h0000;
    end
  end

  // ==========================================================================
  // Millisecond tick
  // All stretch and blink timing counts these pulses, so a short MS_CYCLES
  // shrinks every period alike and keeps their ratios.
  logic [31:0] ms_cnt;
  logic        ms_tick;
  always_ff @(posedge clk) begin
    if (rst || ms_cnt == 32'(MS_CYCLES - 1)) begin
      ms_cnt <= 32'h0000_0000;
    end else begin
      ms_cnt <= ms_cnt + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == 32'(MS_CYCLES - 1));
    end
  end

  // Reserved period code falls back to the shortest time, so a stray write
  // never leaves a lamp lit longer than any defined setting.
  function automatic logic [lesc_pkg::MS_W-1:0] period_ms(logic [1:0] p);
    case (p)
      2'h1:    period_ms = lesc_pkg::MS_W'(lesc_pkg::TIME1_MS);
      2'h2:    period_ms = lesc_pkg::MS_W'(lesc_pkg::TIME2_MS);
      default: period_ms = lesc_pkg::MS_W'(lesc_pkg::TIME0_MS);
    endcase
  endfunction
  wire [lesc_pkg::MS_W-1:0] load_ms = period_ms(period_sel);

  // ==========================================================================
  // Blink sources for test modes
  // Both run free from reset, so all test-mode lamps share one phase.
  logic [lesc_pkg::MS_W-1:0] fast_cnt;
  logic [lesc_pkg::MS_W-1:0] slow_cnt;
  logic                      fast_blink;
  logic                      slow_blink;
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_cnt   <= '0;
      slow_cnt   <= '0;
      fast_blink <= 1'b0;
      slow_blink <= 1'b0;
    end else if (ms_tick) begin
      if (fast_cnt == lesc_pkg::MS_W'(lesc_pkg::FAST_MS - 1)) begin
        fast_cnt   <= '0;
        fast_blink <= ~fast_blink;
      end else begin
        fast_cnt <= fast_cnt + 1'b1;
      end
      if (slow_cnt == lesc_pkg::MS_W'(lesc_pkg::SLOW_MS - 1)) begin
        slow_cnt   <= '0;
        slow_blink <= ~slow_blink;
      end else begin
        slow_cnt <= slow_cnt + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Per-indicator logic

  // Event that retriggers the stretch window for a given select.
  function automatic logic sel_event(logic [3:0] s,
                                     lesc_pkg::lesc_status_s st);
    case (s)
      lesc_pkg::SEL_TX:       sel_event = st.tx;
      lesc_pkg::SEL_RX,
      lesc_pkg::SEL_LINK_RX:  sel_event = st.rx;
      lesc_pkg::SEL_COL,
      lesc_pkg::SEL_DUP_COL:  sel_event = st.col;
      lesc_pkg::SEL_ACT,
      lesc_pkg::SEL_LINK_ACT: sel_event = st.rx || st.tx;
      default:                sel_event = 1'b0;
    endcase
  endfunction

  // Combined selections bypass the stretch enable bit entirely.
  function automatic logic is_combined(logic [3:0] s);
    is_combined = (s == lesc_pkg::SEL_LINK_RX) ||
                  (s == lesc_pkg::SEL_LINK_ACT) ||
                  (s == lesc_pkg::SEL_DUP_COL);
  endfunction

  for (genvar i = 0; i < 3; i++) begin : g_ind
    logic [lesc_pkg::MS_W-1:0] hold_ms;
    logic                      toggle;
    wire  ev      = sel_event(sel[i], status);
    wire  comb    = is_combined(sel[i]);
    wire  do_str  = stretch_en || comb;
    wire  held    = ev || (hold_ms != '0);
    wire  shown   = do_str ? held : ev;
    // Duplex is the solid source for duplex-collision, link for the others.
    wire  primary = (sel[i] == lesc_pkg::SEL_DUP_COL) ?
                    status.duplex : status.link;
    logic next_led;

    // Window restarts on every event and counts down in milliseconds.
    // A new period setting takes effect at the next event, not mid-window.
    always_ff @(posedge clk) begin
      if (rst) begin
        hold_ms <= '0;
      end else if (ev) begin
        hold_ms <= load_ms;
      end else if (ms_tick && hold_ms != '0) begin
        hold_ms <= hold_ms - 1'b1;
      end
    end

    // In combined modes the stretched secondary event flips the lamp at
    // the fast blink rate, so a burst shows as blinking over solid on.
    // Flips follow the shared fast blink boundary so combined lamps blink in
    // step; the price is that a very short burst may end before any flip.
    always_ff @(posedge clk) begin
      if (rst || !held) begin
        toggle <= 1'b0;
      end else if (ms_tick && fast_cnt == '0) begin
        toggle <= ~toggle;
      end
    end

    always_comb begin
      case (sel[i])
        lesc_pkg::SEL_SPEED:    next_led = status.speed_100;
        lesc_pkg::SEL_TX,
        lesc_pkg::SEL_RX,
        lesc_pkg::SEL_COL,
        lesc_pkg::SEL_ACT:      next_led = shown;
        lesc_pkg::SEL_LINK:     next_led = status.link;
        lesc_pkg::SEL_DUPLEX:   next_led = status.duplex;
        lesc_pkg::SEL_ON:       next_led = 1'b1;
        lesc_pkg::SEL_OFF:      next_led = 1'b0;
        lesc_pkg::SEL_FAST:     next_led = fast_blink;
        lesc_pkg::SEL_SLOW:     next_led = slow_blink;
        lesc_pkg::SEL_LINK_RX,
        lesc_pkg::SEL_LINK_ACT,
        lesc_pkg::SEL_DUP_COL:  next_led = primary ^ (held && toggle);
        default:                next_led = 1'b0;
      endcase
    end

    // ========================================================================
    // Output register
    // Each lamp comes straight from a flip-flop, so pin timing does not
    // depend on the depth of the select decode.
    always_ff @(posedge clk) begin
      if (rst) begin
        indicator[i] <= 1'b0;
      end else begin
        indicator[i] <= next_led;
      end
    end
  end

endmodule
`default_nettype wire
